// [inc/fac_pkg.sv]
// Constants and types of the flash abort and ECC capture block
package fac_pkg;

	// Register byte addresses on the processor bus
	localparam logic [31:0] ADDR_UNLOCK_KEY   = 32'h40018020;
	localparam logic [31:0] ADDR_ABORT_ADDR   = 32'h40018040;
	localparam logic [31:0] ADDR_ABORT_EN     = 32'h40018048;
	localparam logic [31:0] ADDR_KEY_LOW      = 32'h40018068;
	localparam logic [31:0] ADDR_KEY_HIGH     = 32'h4001806C;
	localparam logic [31:0] ADDR_PECC         = 32'h40018074;
	localparam logic [31:0] ADDR_DECC         = 32'h40018078;
	localparam logic [31:0] ADDR_IRQ_STATUS   = 32'h40018080;
	localparam logic [31:0] ADDR_IRQ_MASK     = 32'h40018084;

	// Values after reset
	localparam logic [31:0] RST_ABORT_ADDR    = 32'h00000000;
	localparam logic [15:0] RST_ABORT_EN      = 16'h0000;
	localparam logic [31:0] RST_KEY_WORD      = 32'h00000000;
	localparam logic [19:0] RST_ECC_ADDR      = 20'h00000;
	localparam logic [3:0]  RST_IRQ_MASK      = 4'h0;

	// Unlock sequence values
	localparam logic [15:0] KEY_FIRST         = 16'hF456;
	localparam logic [15:0] KEY_SECOND        = 16'hF123;

	// Field layout
	localparam int          ABORT_EN_WIDTH    = 16;
	localparam int          IRQ_SRC_COUNT     = 14;
	localparam int          ECC_ADDR_MSB      = 22;
	localparam int          ECC_ADDR_LSB      = 3;
	localparam int          KEY_STATE_LSB     = 4;

	// Event bits of status and mask
	localparam int          EV_ABORT          = 0;
	localparam int          EV_PECC           = 1;
	localparam int          EV_DECC           = 2;
	localparam int          EV_KEY_REFUSED    = 3;
	localparam int          EV_COUNT          = 4;

	// Synchroniser depth for inputs from outside the clock domain
	localparam int          SYNC_STAGES       = 3;

	// Unlock sequence state, Gray along the usual path
	typedef enum logic [1:0] {
		FAC_KEY_LOCKED = 2'b00,
		FAC_KEY_HALF   = 2'b01,
		FAC_KEY_OPEN   = 2'b11
	} fac_key_state_t;

endpackage

// [inc/fac_reg_if.sv]
// Register access strobes between the bus slave and the register file
interface fac_reg_if;
	logic        wr;
	logic        rd;
	logic        peek;
	logic [31:0] addr;
	logic [31:0] wdata;
	logic [31:0] rdata;
	logic        hit;

	modport bus (
		output wr,
		output rd,
		output peek,
		output addr,
		output wdata,
		input  rdata,
		input  hit
	);

	modport regs (
		input  wr,
		input  rd,
		input  peek,
		input  addr,
		input  wdata,
		output rdata,
		output hit
	);
endinterface

// [verilog/fac_sync.sv]
// Three-stage synchroniser with agreement filter, one lane per bit
module fac_sync #(
	parameter int WIDTH = 14
) (
	// Clock and reset
	input  wire logic             clk_i,
	input  wire logic             reset_i,
	// Lanes
	input  wire logic [WIDTH-1:0] async_i,
	output logic      [WIDTH-1:0] sync_o
);

	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_lane
			logic [fac_pkg::SYNC_STAGES-1:0] stage;

			always_ff @(posedge clk_i or posedge reset_i) begin
				if (reset_i) begin
					stage <= '0;
				end else begin
					stage <= {stage[fac_pkg::SYNC_STAGES-2:0], async_i[i]};
				end
			end

			// Only a level that two later stages agree on is passed
			always_ff @(posedge clk_i or posedge reset_i) begin
				if (reset_i) begin
					sync_o[i] <= 1'b0;
				end else if (stage[1] == stage[2]) begin
					sync_o[i] <= stage[2];
				end
			end
		end
	endgenerate

endmodule

// [verilog/fac_apb.sv]
// APB slave front end: zero-wait access, read data latched in setup
module fac_apb (
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        reset_i,
	// APB
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [31:0] paddr_i,
	input  wire logic [31:0] pwdata_i,
	output logic      [31:0] prdata_o,
	output logic             pready_o,
	output logic             pslverr_o,
	// Register file side
	fac_reg_if.bus           rif
);

	logic setup;
	logic access;

	assign setup      = psel_i & ~penable_i;
	assign access     = psel_i & penable_i;
	assign rif.addr   = paddr_i;
	assign rif.wdata  = pwdata_i;
	assign rif.wr     = access & pwrite_i & rif.hit;
	assign rif.rd     = access & ~pwrite_i & rif.hit;
	assign rif.peek   = setup & ~pwrite_i & rif.hit;
	assign pready_o   = 1'b1;
	assign pslverr_o  = access & ~rif.hit;

	// Snapshot in setup so read-to-clear knows exactly what was shown
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			prdata_o <= 32'h00000000;
		end else if (setup) begin
			prdata_o <= rif.hit & ~pwrite_i ? rif.rdata : 32'h00000000;
		end
	end

endmodule

// [verilog/fac_top.sv]
// Flash abort control, failure-analysis key and ECC error address capture
//
// Operation
// - Abort captures address being written into register.
// - Abort address register reads zero after reset.
// - Enabled interrupts 0..13 abort running flash operation.
// - Value 0x4 enables first external interrupt.
// - Analysis key is 64 bits in two words.
// - Key writes only after 0xF456 then 0xF123.
// - Program ECC error address stored in bits 22:3.
// - Data ECC error address stored in bits 22:3.
// - Reading ECC address registers does not clear them.
//
// Design decision made here: the APB interface to the registers.
module fac_top (
	// Clock and reset
	input  wire logic        MCLK_I,
	input  wire logic        RESET_I,
	// APB register bus
	input  wire logic        PSEL_I,
	input  wire logic        PENABLE_I,
	input  wire logic        PWRITE_I,
	input  wire logic [31:0] PADDR_I,
	input  wire logic [31:0] PWDATA_I,
	output logic      [31:0] PRDATA_O,
	output logic             PREADY_O,
	output logic             PSLVERR_O,
	// System interrupt lines, asynchronous
	input  wire logic [13:0] SYS_IRQ_I,
	// Flash operation engine
	input  wire logic        FLASH_BUSY_I,
	input  wire logic [31:0] FLASH_ADDR_I,
	output logic             FLASH_ABORT_O,
	// ECC error reports
	input  wire logic        PECC_ERR_I,
	input  wire logic [31:0] PECC_ADDR_I,
	input  wire logic        DECC_ERR_I,
	input  wire logic [31:0] DECC_ADDR_I,
	// Key and interrupt outputs
	output logic      [63:0] FA_KEY_O,
	output logic             KEY_OPEN_O,
	output logic             IRQ_O
);

	localparam int EW = fac_pkg::ECC_ADDR_MSB - fac_pkg::ECC_ADDR_LSB + 1;
	localparam int NE = fac_pkg::EV_COUNT;

	fac_reg_if rif ();

	fac_pkg::fac_key_state_t key_state;
	fac_pkg::fac_key_state_t next_key_state;

	logic [31:0]                         abort_addr;
	logic [fac_pkg::ABORT_EN_WIDTH-1:0]  abort_en;
	logic [31:0]                         key_low;
	logic [31:0]                         key_high;
	logic [EW-1:0]                       pecc_addr;
	logic [EW-1:0]                       decc_addr;
	logic [NE-1:0]                       irq_status;
	logic [NE-1:0]                       irq_mask;
	logic [NE-1:0]                       status_seen;
	logic [NE-1:0]                       events;
	logic [fac_pkg::IRQ_SRC_COUNT-1:0]   irq_sync;
	logic                                abort_hit;
	logic                                abort_armed;
	logic                                abort_fire;
	logic                                key_refused;
	logic                                wr_unlock;
	logic                                wr_key_low;
	logic                                wr_key_high;
	logic                                rd_status;
	logic                                peek_status;
	logic                                wr_abort_en;
	logic                                wr_irq_mask;

	// Bus slave
	// Zero wait states; read data is snapshot in the setup cycle
	fac_apb i_fac_apb (
		.clk_i     (MCLK_I),
		.reset_i   (RESET_I),
		.psel_i    (PSEL_I),
		.penable_i (PENABLE_I),
		.pwrite_i  (PWRITE_I),
		.paddr_i   (PADDR_I),
		.pwdata_i  (PWDATA_I),
		.prdata_o  (PRDATA_O),
		.pready_o  (PREADY_O),
		.pslverr_o (PSLVERR_O),
		.rif       (rif.bus)
	);

	// Interrupt lines come from pins and other blocks
	// Costs four to five cycles of abort latency, avoids metastability
	fac_sync #(
		.WIDTH (fac_pkg::IRQ_SRC_COUNT)
	) i_fac_sync (
		.clk_i   (MCLK_I),
		.reset_i (RESET_I),
		.async_i (SYS_IRQ_I),
		.sync_o  (irq_sync)
	);

	// Address decode
	// Full byte address compared, so aliases never hit
	always_comb begin
		case (rif.addr)
			fac_pkg::ADDR_UNLOCK_KEY,
			fac_pkg::ADDR_ABORT_ADDR,
			fac_pkg::ADDR_ABORT_EN,
			fac_pkg::ADDR_KEY_LOW,
			fac_pkg::ADDR_KEY_HIGH,
			fac_pkg::ADDR_PECC,
			fac_pkg::ADDR_DECC,
			fac_pkg::ADDR_IRQ_STATUS,
			fac_pkg::ADDR_IRQ_MASK: rif.hit = 1'b1;
			default: rif.hit = 1'b0;
		endcase
	end

	// Read mux; unlock key always reads zero
	always_comb begin
		rif.rdata = 32'h00000000;
		case (rif.addr)
			fac_pkg::ADDR_ABORT_ADDR: begin
				rif.rdata = abort_addr;
			end
			fac_pkg::ADDR_ABORT_EN: begin
				rif.rdata[fac_pkg::ABORT_EN_WIDTH-1:0] = abort_en;
			end
			fac_pkg::ADDR_KEY_LOW: begin
				rif.rdata = key_low;
			end
			fac_pkg::ADDR_KEY_HIGH: begin
				rif.rdata = key_high;
			end
			fac_pkg::ADDR_PECC: begin
				rif.rdata[fac_pkg::ECC_ADDR_MSB:fac_pkg::ECC_ADDR_LSB]
					= pecc_addr;
			end
			fac_pkg::ADDR_DECC: begin
				rif.rdata[fac_pkg::ECC_ADDR_MSB:fac_pkg::ECC_ADDR_LSB]
					= decc_addr;
			end
			fac_pkg::ADDR_IRQ_STATUS: begin
				rif.rdata[NE-1:0] = irq_status;
				rif.rdata[fac_pkg::KEY_STATE_LSB+1:fac_pkg::KEY_STATE_LSB]
					= key_state;
			end
			fac_pkg::ADDR_IRQ_MASK: begin
				rif.rdata[NE-1:0] = irq_mask;
			end
			default: begin
				rif.rdata = 32'h00000000;
			end
		endcase
	end

	// Write and read strobes per register
	assign wr_unlock   = rif.wr & (rif.addr == fac_pkg::ADDR_UNLOCK_KEY);
	assign wr_key_low  = rif.wr & (rif.addr == fac_pkg::ADDR_KEY_LOW);
	assign wr_key_high = rif.wr & (rif.addr == fac_pkg::ADDR_KEY_HIGH);
	assign rd_status   = rif.rd & (rif.addr == fac_pkg::ADDR_IRQ_STATUS);
	assign peek_status = rif.peek & (rif.addr == fac_pkg::ADDR_IRQ_STATUS);
	assign wr_abort_en = rif.wr & (rif.addr == fac_pkg::ADDR_ABORT_EN);
	assign wr_irq_mask = rif.wr & (rif.addr == fac_pkg::ADDR_IRQ_MASK);

	// Unlock sequence
	// Other register accesses leave the sequence where it is
	always_comb begin
		next_key_state = key_state;
		if (wr_unlock) begin
			case (key_state)
				fac_pkg::FAC_KEY_LOCKED: begin
					if (rif.wdata[15:0] == fac_pkg::KEY_FIRST) begin
						next_key_state = fac_pkg::FAC_KEY_HALF;
					end
				end
				fac_pkg::FAC_KEY_HALF: begin
					if (rif.wdata[15:0] == fac_pkg::KEY_SECOND) begin
						next_key_state = fac_pkg::FAC_KEY_OPEN;
					end else if (rif.wdata[15:0] == fac_pkg::KEY_FIRST) begin
						next_key_state = fac_pkg::FAC_KEY_HALF;
					end else begin
						next_key_state = fac_pkg::FAC_KEY_LOCKED;
					end
				end
				fac_pkg::FAC_KEY_OPEN: begin
					// Any further key value closes the window
					next_key_state = fac_pkg::FAC_KEY_LOCKED;
				end
				default: begin
					next_key_state = fac_pkg::FAC_KEY_LOCKED;
				end
			endcase
		end
	end

	always_ff @(posedge MCLK_I or posedge RESET_I) begin
		if (RESET_I) begin
			key_state <= fac_pkg::FAC_KEY_LOCKED;
		end else begin
			key_state <= next_key_state;
		end
	end

	assign KEY_OPEN_O  = key_state == fac_pkg::FAC_KEY_OPEN;
	// Refused key writes are flagged so software can see stray writes
	assign key_refused = (wr_key_low | wr_key_high) & ~KEY_OPEN_O;

	// Failure-analysis key, writable only while unlocked
	always_ff @(posedge MCLK_I or posedge RESET_I) begin
		if (RESET_I) begin
			key_low <= fac_pkg::RST_KEY_WORD;
		end else if (KEY_OPEN_O & wr_key_low) begin
			key_low <= rif.wdata;
		end
	end

	always_ff @(posedge MCLK_I or posedge RESET_I) begin
		if (RESET_I) begin
			key_high <= fac_pkg::RST_KEY_WORD;
		end else if (KEY_OPEN_O & wr_key_high) begin
			key_high <= rif.wdata;
		end
	end

	assign FA_KEY_O = {key_high, key_low};

	// Abort source enable; bit 2 is the first external interrupt
	always_ff @(posedge MCLK_I or posedge RESET_I) begin
		if (RESET_I) begin
			abort_en <= fac_pkg::RST_ABORT_EN;
		end else if (wr_abort_en) begin
			// Upper two bits are stored but drive nothing
			abort_en <= rif.wdata[fac_pkg::ABORT_EN_WIDTH-1:0];
		end
	end

	// Abort fires once per operation; armed until busy drops
	assign abort_hit = FLASH_BUSY_I
		& |(irq_sync & abort_en[fac_pkg::IRQ_SRC_COUNT-1:0]);
	// Combinational so the address is taken on the deciding edge
	assign abort_fire = abort_hit & ~abort_armed;

	always_ff @(posedge MCLK_I or posedge RESET_I) begin
		if (RESET_I) begin
			abort_armed <= 1'b0;
		end else if (!FLASH_BUSY_I) begin
			abort_armed <= 1'b0;
		end else if (abort_fire) begin
			abort_armed <= 1'b1;
		end
	end

	always_ff @(posedge MCLK_I or posedge RESET_I) begin
		if (RESET_I) begin
			FLASH_ABORT_O <= 1'b0;
		end else begin
			FLASH_ABORT_O <= abort_fire;
		end
	end

	// Held until the next abort; software must fetch it before
	// starting another command, which may abort and overwrite it
	always_ff @(posedge MCLK_I or posedge RESET_I) begin
		if (RESET_I) begin
			abort_addr <= fac_pkg::RST_ABORT_ADDR;
		end else if (abort_fire) begin
			abort_addr <= FLASH_ADDR_I;
		end
	end

	// ECC error addresses; bus reads leave them alone
	always_ff @(posedge MCLK_I or posedge RESET_I) begin
		if (RESET_I) begin
			pecc_addr <= fac_pkg::RST_ECC_ADDR;
		end else if (PECC_ERR_I) begin
			pecc_addr <= PECC_ADDR_I[fac_pkg::ECC_ADDR_MSB:
				fac_pkg::ECC_ADDR_LSB];
		end
	end

	always_ff @(posedge MCLK_I or posedge RESET_I) begin
		if (RESET_I) begin
			decc_addr <= fac_pkg::RST_ECC_ADDR;
		end else if (DECC_ERR_I) begin
			decc_addr <= DECC_ADDR_I[fac_pkg::ECC_ADDR_MSB:
				fac_pkg::ECC_ADDR_LSB];
		end
	end

	// Interrupt status
	// One event per cycle per source; sources are single-cycle pulses
	always_comb begin
		events                          = '0;
		events[fac_pkg::EV_ABORT]       = abort_fire;
		events[fac_pkg::EV_PECC]        = PECC_ERR_I;
		events[fac_pkg::EV_DECC]        = DECC_ERR_I;
		events[fac_pkg::EV_KEY_REFUSED] = key_refused;
	end

	// Bits shown in setup are the only ones a read may clear
	always_ff @(posedge MCLK_I or posedge RESET_I) begin
		if (RESET_I) begin
			status_seen <= '0;
		end else if (peek_status) begin
			status_seen <= irq_status;
		end
	end

	// New events win over the read clear in the same cycle
	always_ff @(posedge MCLK_I or posedge RESET_I) begin
		if (RESET_I) begin
			irq_status <= '0;
		end else if (rd_status) begin
			irq_status <= (irq_status & ~status_seen) | events;
		end else begin
			irq_status <= irq_status | events;
		end
	end

	always_ff @(posedge MCLK_I or posedge RESET_I) begin
		if (RESET_I) begin
			irq_mask <= fac_pkg::RST_IRQ_MASK;
		end else if (wr_irq_mask) begin
			irq_mask <= rif.wdata[NE-1:0];
		end
	end

	// Level output; drops once the status read has cleared the cause
	assign IRQ_O = |(irq_status & irq_mask);

endmodule

// [testbench/fac_top_assertions.sv]
// Concurrent checks on the top-level ports of the abort and key block
module fac_top_assertions (
	// Clock and reset
	input  wire logic        MCLK_I,
	input  wire logic        RESET_I,
	// APB
	input  wire logic        PSEL_I,
	input  wire logic        PENABLE_I,
	input  wire logic        PWRITE_I,
	input  wire logic [31:0] PADDR_I,
	input  wire logic [31:0] PWDATA_I,
	input  wire logic [31:0] PRDATA_O,
	// Abort and key
	input  wire logic [13:0] SYS_IRQ_I,
	input  wire logic        FLASH_BUSY_I,
	input  wire logic        FLASH_ABORT_O,
	input  wire logic [63:0] FA_KEY_O,
	input  wire logic        KEY_OPEN_O
);
	timeunit 1ns;
	timeprecision 1ps;
	logic rd_s;
	logic kw_a;
	logic sec_a;
	assign rd_s  = PSEL_I && !PENABLE_I && !PWRITE_I;
	assign kw_a  = PSEL_I && PENABLE_I && PWRITE_I
		&& PADDR_I == fac_pkg::ADDR_UNLOCK_KEY;
	assign sec_a = kw_a && PWDATA_I[15:0] == fac_pkg::KEY_SECOND;
	default clocking @(posedge MCLK_I); endclocking
	default disable iff (RESET_I);
	AST_ABORT_BUSY: assert property (
		FLASH_ABORT_O |-> $past(FLASH_BUSY_I))
		else $error("abort outside busy");
	AST_ABORT_PULSE: assert property (
		FLASH_ABORT_O |=> !FLASH_ABORT_O)
		else $error("abort longer than one cycle");
	// Synchroniser lag leaves the cause four to six edges back
	AST_ABORT_CAUSE: assert property (
		FLASH_ABORT_O |-> ($past(SYS_IRQ_I, 4) | $past(SYS_IRQ_I, 5)
		| $past(SYS_IRQ_I, 6)) != 14'h0)
		else $error("abort without interrupt");
	AST_KEY_HOLD: assert property (
		!KEY_OPEN_O |=> $stable(FA_KEY_O))
		else $error("key changed while locked");
	AST_KEY_OPEN: assert property (
		$rose(KEY_OPEN_O) |-> $past(sec_a))
		else $error("unlock without second key");
	AST_KEY_RELOCK: assert property (
		KEY_OPEN_O && kw_a |=> !KEY_OPEN_O)
		else $error("unlock write did not relock");
	AST_PECC_RSVD: assert property (
		rd_s && PADDR_I == fac_pkg::ADDR_PECC
		|=> PRDATA_O[31:23] == 9'h0 && PRDATA_O[2:0] == 3'h0)
		else $error("program ecc reserved bits set");
	AST_DECC_RSVD: assert property (
		rd_s && PADDR_I == fac_pkg::ADDR_DECC
		|=> PRDATA_O[31:23] == 9'h0 && PRDATA_O[2:0] == 3'h0)
		else $error("data ecc reserved bits set");
endmodule

bind fac_top fac_top_assertions i_fac_top_assertions (
	.MCLK_I(MCLK_I), .RESET_I(RESET_I), .PSEL_I(PSEL_I),
	.PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I),
	.PWDATA_I(PWDATA_I), .PRDATA_O(PRDATA_O), .SYS_IRQ_I(SYS_IRQ_I),
	.FLASH_BUSY_I(FLASH_BUSY_I), .FLASH_ABORT_O(FLASH_ABORT_O),
	.FA_KEY_O(FA_KEY_O), .KEY_OPEN_O(KEY_OPEN_O)
);

// [testbench/fac_flash_model.sv]
// Flash operation engine stand-in: walks addresses until done or aborted
module fac_flash_model (
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        reset_i,
	// Control
	input  wire logic        go_i,
	input  wire logic [31:0] base_i,
	input  wire logic        abort_i,
	// Engine state
	output logic             busy_o,
	output logic [31:0]      addr_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [5:0] left;
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			busy_o <= 1'b0;
			addr_o <= 32'h0;
			left   <= 6'h0;
		end else if (busy_o && !abort_i && left != 6'h0) begin
			addr_o <= addr_o + 32'h4;
			left   <= left - 6'h1;
		end else if (go_i && !busy_o) begin
			busy_o <= 1'b1;
			addr_o <= base_i;
			left   <= 6'h28;
		end else begin
			busy_o <= 1'b0;
			// Idle bus toggles so a stale address never looks valid
			addr_o <= ~addr_o;
		end
	end
endmodule

// [testbench/test_flash_abort_and_ecc_capture.sv]
// Self-checking bench for the flash abort and ECC capture block
module test_flash_abort_and_ecc_capture;
	timeunit 1ns;
	timeprecision 1ps;
	logic        MCLK_I, RESET_I, PSEL_I, PENABLE_I, PWRITE_I;
	logic        PREADY_O, PSLVERR_O, FLASH_BUSY_I, FLASH_ABORT_O;
	logic        PECC_ERR_I, DECC_ERR_I, KEY_OPEN_O, IRQ_O, go;
	logic [31:0] PADDR_I, PWDATA_I, PRDATA_O, FLASH_ADDR_I;
	logic [31:0] PECC_ADDR_I, DECC_ADDR_I, base, last_addr, ea, a;
	logic [13:0] SYS_IRQ_I;
	logic [63:0] FA_KEY_O, kv;
	logic [32:0] rq[$];
	logic [7:0]  ro[9] = '{8'h40, 8'h48, 8'h68, 8'h6C, 8'h74, 8'h78,
		8'h20, 8'h80, 8'h84};
	int          errors, cmp_count, seed, n;

	fac_top i_fac_top (
		.MCLK_I(MCLK_I), .RESET_I(RESET_I), .PSEL_I(PSEL_I),
		.PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I),
		.PWDATA_I(PWDATA_I), .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O),
		.PSLVERR_O(PSLVERR_O), .SYS_IRQ_I(SYS_IRQ_I),
		.FLASH_BUSY_I(FLASH_BUSY_I), .FLASH_ADDR_I(FLASH_ADDR_I),
		.FLASH_ABORT_O(FLASH_ABORT_O), .PECC_ERR_I(PECC_ERR_I),
		.PECC_ADDR_I(PECC_ADDR_I), .DECC_ERR_I(DECC_ERR_I),
		.DECC_ADDR_I(DECC_ADDR_I), .FA_KEY_O(FA_KEY_O),
		.KEY_OPEN_O(KEY_OPEN_O), .IRQ_O(IRQ_O));
	fac_flash_model i_fac_flash_model (
		.clk_i(MCLK_I), .reset_i(RESET_I), .go_i(go), .base_i(base),
		.abort_i(FLASH_ABORT_O), .busy_o(FLASH_BUSY_I),
		.addr_o(FLASH_ADDR_I));

	task automatic chk(input string nm, input logic [63:0] seen, exp);
		cmp_count++;
		if (seen !== exp) begin
			errors++;
			$display("[ERR] %s exp %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic test_done;
		if (errors == 0 && cmp_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// Reads leave {slverr, data} for the monitor; idle cycle after each
	task automatic apb(input logic w, input logic [31:0] ad, d,
		input logic [32:0] e);
		int k;
		PSEL_I   <= 1'b1;
		PWRITE_I <= w;
		PADDR_I  <= ad;
		PWDATA_I <= d;
		if (!w)
			rq.push_back(e);
		@(posedge MCLK_I);
		PENABLE_I <= 1'b1;
		for (k = 0; k < 20; k++) begin
			@(posedge MCLK_I);
			if (PREADY_O === 1'b1)
				break;
		end
		if (k == 20) begin
			chk("pready", 0, 1);
			test_done();
		end
		PSEL_I    <= 1'b0;
		PENABLE_I <= 1'b0;
		@(posedge MCLK_I);
	endtask

	always @(posedge MCLK_I) begin
		last_addr <= FLASH_ADDR_I;
		if (PSEL_I && PENABLE_I && !PWRITE_I) begin
			if (rq.size() == 0)
				chk("read note", 0, 1);
			else
				chk("read", {PSLVERR_O, PRDATA_O}, rq.pop_front());
		end
	end

	initial begin
		MCLK_I = 1'b0;
		forever #4 MCLK_I = ~MCLK_I;
	end

	initial begin
		repeat (100000) @(posedge MCLK_I);
		chk("timeout", 0, 1);
		test_done();
	end

	initial begin
		seed = 80951;
		RESET_I = 1'b1;
		{PSEL_I, PENABLE_I, PWRITE_I, PECC_ERR_I, DECC_ERR_I, go} = 6'h0;
		{PADDR_I, PWDATA_I, PECC_ADDR_I, DECC_ADDR_I, base} = 160'h0;
		SYS_IRQ_I = 14'h0;
		repeat (16) @(posedge MCLK_I);
		RESET_I <= 1'b0;
		@(posedge MCLK_I);
		foreach (ro[i])
			apb(1'b0, 32'h40018000 | ro[i], 32'h0, 33'h0);
		apb(1'b0, 32'h40018044, 32'h0, {1'b1, 32'h0});
		kv = {$random(seed), $random(seed)};
		apb(1'b1, fac_pkg::ADDR_IRQ_MASK, 32'h8, 33'h0);
		apb(1'b1, fac_pkg::ADDR_KEY_LOW, kv[31:0], 33'h0);
		@(negedge MCLK_I);
		chk("irq", IRQ_O, 1'b1);
		chk("key", FA_KEY_O, 64'h0);
		@(posedge MCLK_I);
		apb(1'b0, fac_pkg::ADDR_IRQ_STATUS, 32'h0, 33'h8);
		@(negedge MCLK_I);
		chk("irq", IRQ_O, 1'b0);
		@(posedge MCLK_I);
		apb(1'b1, fac_pkg::ADDR_UNLOCK_KEY, fac_pkg::KEY_FIRST, 33'h0);
		apb(1'b1, fac_pkg::ADDR_UNLOCK_KEY, fac_pkg::KEY_SECOND, 33'h0);
		apb(1'b1, fac_pkg::ADDR_KEY_LOW, kv[31:0], 33'h0);
		apb(1'b1, fac_pkg::ADDR_KEY_HIGH, kv[63:32], 33'h0);
		apb(1'b0, fac_pkg::ADDR_KEY_LOW, 0, {1'b0, kv[31:0]});
		apb(1'b0, fac_pkg::ADDR_KEY_HIGH, 0, {1'b0, kv[63:32]});
		apb(1'b1, fac_pkg::ADDR_UNLOCK_KEY, 32'h0, 33'h0);
		apb(1'b1, fac_pkg::ADDR_KEY_HIGH, ~kv[63:32], 33'h0);
		@(negedge MCLK_I);
		chk("open", KEY_OPEN_O, 1'b0);
		chk("key", FA_KEY_O, kv);
		@(posedge MCLK_I);
		for (int i = 0; i < 14; i++) begin
			apb(1'b1, fac_pkg::ADDR_ABORT_EN, 32'h1 << i, 33'h0);
			apb(1'b0, fac_pkg::ADDR_ABORT_EN, 0, {1'b0, 32'h1 << i});
			go   <= 1'b1;
			base <= $random(seed) & 32'h007FFFFC;
			@(posedge MCLK_I);
			go        <= 1'b0;
			SYS_IRQ_I <= 14'h1 << i;
			for (n = 0; n < 40 && FLASH_ABORT_O !== 1'b1; n++)
				@(negedge MCLK_I);
			chk("abort", FLASH_ABORT_O, 1'b1);
			if (FLASH_ABORT_O !== 1'b1)
				test_done();
			ea = last_addr;
			@(posedge MCLK_I);
			SYS_IRQ_I <= 14'h0;
			apb(1'b0, fac_pkg::ADDR_ABORT_ADDR, 0, {1'b0, ea});
		end
		go <= 1'b1;
		@(posedge MCLK_I);
		go        <= 1'b0;
		SYS_IRQ_I <= 14'h0FFF;
		n = 0;
		repeat (48) begin
			@(negedge MCLK_I);
			if (FLASH_ABORT_O !== 1'b0)
				n++;
		end
		chk("no abort", n, 0);
		@(posedge MCLK_I);
		SYS_IRQ_I <= 14'h0;
		apb(1'b0, fac_pkg::ADDR_ABORT_ADDR, 0, {1'b0, ea});
		for (int c = 0; c < 4; c++) begin
			a = $random(seed);
			PECC_ERR_I  <= c < 2;
			DECC_ERR_I  <= c >= 2;
			PECC_ADDR_I <= a;
			DECC_ADDR_I <= a;
			@(posedge MCLK_I);
			{PECC_ERR_I, DECC_ERR_I} <= 2'b00;
			PECC_ADDR_I <= ~a;
			DECC_ADDR_I <= ~a;
			ea = c < 2 ? fac_pkg::ADDR_PECC : fac_pkg::ADDR_DECC;
			repeat (2)
				apb(1'b0, ea, 0, {1'b0, a & 32'h007FFFF8});
		end
		test_done();
	end
endmodule
